// file: design/remote_image_upgrade_sequencer.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module remote_image_upgrade_sequencer
  import upgrade_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Configuration pins
  input wire logic config_status_line_n,
  input wire logic config_request_n,
  input wire logic [3:0] scheme_select_pins,
  input wire logic remote_mode_enable,
  input wire logic chain_member,
  input wire logic security_variant,
  // Test-port address override
  input wire logic factory_address_override_cmd,
  input wire logic [BOOT_W-1:0] override_address,
  // Image fetch engine
  input wire logic image_crc_error,
  input wire logic image_load_done,
  output logic load_request,
  output logic [BOOT_W-1:0] load_address,
  output logic load_word_units,
  // Mode and interrupt
  output logic user_mode,
  output logic factory_image,
  output logic remote_active,
  output logic irq
);

  // Pin filtering
  pin_sync_if #(.W(SYNC_W)) pin_bus ();
  assign pin_bus.raw = {scheme_select_pins, security_variant,
                        chain_member, remote_mode_enable,
                        factory_address_override_cmd, image_load_done,
                        image_crc_error, config_request_n,
                        config_status_line_n};

  pin_filter #(.W(SYNC_W), .INIT(PIN_RESET)) u_filter (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .pins(pin_bus.filt)
  );

  // Filtered pin views
  logic [SYNC_W-1:0] pin; // Whole clean bundle
  logic status_low; // Status line pulled low
  logic request_low; // Pin configuration reset
  logic crc_err; // Fetch engine CRC error
  logic load_done; // Fetch engine done
  logic ovr_cmd; // Override command level
  logic ovr_cmd_q; // For its rising edge
  scheme_t scheme; // Decoded boot scheme
  assign pin = pin_bus.clean;
  assign status_low = !pin[PIN_STATUS_N];
  assign request_low = !pin[PIN_REQUEST_N];
  assign crc_err = pin[PIN_CRC];
  assign load_done = pin[PIN_LOAD_DONE];
  assign ovr_cmd = pin[PIN_OVR_CMD];
  assign scheme = decode_scheme(pin[PIN_SCHEME_LSB +: 4]);

  // Remote update allowed in this setup
  logic next_remote;
  always_comb begin
    next_remote = pin[PIN_REMOTE_EN];
    if (pin[PIN_CHAIN]) begin
      next_remote = 1'b0;
    end
    if (scheme == SCHEME_NONE) begin
      next_remote = 1'b0;
    end
    if (pin[PIN_SECURE] && scheme == SCHEME_PARALLEL) begin
      next_remote = 1'b0;
    end
  end

  // Registered so the output is a flop
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      remote_active <= 1'b0;
    end else begin
      remote_active <= next_remote;
    end
  end

  // Register access decode
  logic wr_upd_addr; // Update address write
  logic wr_upd_wd; // Update watchdog write
  logic wr_mask; // Mask write
  logic wr_cmd; // Command write
  logic rd_status; // Status read, clears it
  logic upd_allowed; // Factory image in remote mode
  assign upd_allowed = remote_active && factory_image;
  assign wr_upd_addr = reg_wr && reg_addr == OFF_UPD_ADDR && upd_allowed;
  assign wr_upd_wd = reg_wr && reg_addr == OFF_UPD_WD && upd_allowed;
  assign wr_mask = reg_wr && reg_addr == OFF_MASK;
  assign wr_cmd = reg_wr && reg_addr == OFF_COMMAND;
  assign rd_status = reg_rd && reg_addr == OFF_STATUS;

  // Command strobes
  logic cmd_reconfig; // Core-side reconfiguration trigger
  logic cmd_wd_restart; // Watchdog restart
  assign cmd_reconfig = wr_cmd && reg_wdata[CMD_RECONFIG_BIT];
  assign cmd_wd_restart = wr_cmd && reg_wdata[CMD_WD_RESTART_BIT];

  // Update register, written by the factory image only
  logic [BOOT_W-1:0] upd_addr; // Next image address
  logic [12:0] upd_wd; // Next watchdog enable and timeout
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      upd_addr <= UPD_ADDR_RESET;
      upd_wd <= UPD_WD_RESET;
    end else begin
      // Any sector start is legal, so no alignment check
      if (wr_upd_addr) begin
        upd_addr <= reg_wdata[BOOT_W-1:0];
      end
      if (wr_upd_wd) begin
        upd_wd <= reg_wdata[12:0];
      end
    end
  end

  // Parallel factory address, replaceable by override
  logic [BOOT_W-1:0] par_factory;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      par_factory <= PARALLEL_FACTORY_ADDR;
      ovr_cmd_q <= 1'b0;
    end else begin
      ovr_cmd_q <= ovr_cmd;
      // Address pins must be stable around the command edge
      if (ovr_cmd && !ovr_cmd_q && scheme == SCHEME_PARALLEL) begin
        par_factory <= override_address;
      end
    end
  end

  // Factory address of the active scheme
  logic [BOOT_W-1:0] factory_addr;
  assign factory_addr = (scheme == SCHEME_PARALLEL) ?
                        par_factory : SERIAL_FACTORY_ADDR;

  // Watchdog counter, running in user mode on an application
  logic [WD_CNT_W-1:0] wd_count; // Elapsed cycles
  logic [BOOT_W-1:0] ctl_addr; // Active control address
  logic [12:0] ctl_wd; // Active watchdog settings
  logic [WD_CNT_W-1:0] wd_limit; // Timeout in cycles
  logic wd_running; // Watchdog armed
  logic wd_timeout; // Limit reached
  assign wd_limit = {ctl_wd[WD_W-1:0], WD_LOW_BITS};
  assign wd_running = remote_active && user_mode && !factory_image &&
                      ctl_wd[WD_EN_BIT];
  assign wd_timeout = wd_running && wd_count >= wd_limit;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wd_count <= '0;
    end else if (!wd_running || cmd_wd_restart) begin
      // Restart keeps a healthy image alive
      wd_count <= '0;
    end else if (!wd_timeout) begin
      wd_count <= wd_count + 1'b1;
    end
  end

  // Sequencer state
  seq_state_t state;
  logic in_load; // Fetch under way
  logic in_user; // Image running
  assign in_load = state == ST_LOAD;
  assign in_user = state == ST_USER;

  // Causes seen this cycle
  logic [CAUSE_W-1:0] cause;
  always_comb begin
    cause = '0;
    if (in_load || in_user) begin
      cause[CAUSE_STATUS_LINE] = status_low;
      cause[CAUSE_CRC] = crc_err && in_load;
      cause[CAUSE_WDOG] = wd_timeout;
      // A core trigger from an application image counts as a configuration reset
      cause[CAUSE_CFG_RESET] = request_low ||
                               (cmd_reconfig && !factory_image);
    end
  end

  // Factory triggers go to the image it chose
  logic go_app;
  assign go_app = in_user && factory_image && cmd_reconfig &&
                  remote_active && cause == '0;

  // Main sequence
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_START;
      ctl_addr <= SERIAL_FACTORY_ADDR;
      ctl_wd <= UPD_WD_RESET;
      factory_image <= 1'b1;
      user_mode <= 1'b0;
      load_request <= 1'b0;
    end else begin
      case (state)
        ST_START: begin
          // Hold off while the pin reset is asserted
          user_mode <= 1'b0;
          load_request <= 1'b0;
          ctl_addr <= factory_addr;
          ctl_wd <= UPD_WD_RESET;
          factory_image <= 1'b1;
          if (!request_low) begin
            state <= ST_LOAD;
          end
        end
        ST_COPY: begin
          ctl_addr <= upd_addr;
          ctl_wd <= upd_wd;
          factory_image <= 1'b0;
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          load_request <= 1'b1;
          if (cause != '0) begin
            load_request <= 1'b0;
            state <= ST_START;
          end else if (load_done) begin
            load_request <= 1'b0;
            user_mode <= 1'b1;
            state <= ST_USER;
          end
        end
        ST_USER: begin
          if (cause != '0) begin
            user_mode <= 1'b0;
            state <= ST_START;
          end else if (go_app) begin
            user_mode <= 1'b0;
            state <= ST_COPY;
          end
        end
        default: begin
          state <= ST_START;
        end
      endcase
    end
  end

  // Fetch address output, in words on the parallel scheme
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      load_address <= SERIAL_FACTORY_ADDR;
      load_word_units <= 1'b0;
    end else begin
      load_address <= ctl_addr;
      load_word_units <= scheme == SCHEME_PARALLEL;
    end
  end

  // Status: sticky causes, a read clears, a new cause wins
  logic [CAUSE_W-1:0] status;
  logic [CAUSE_W-1:0] mask;
  logic [CAUSE_W-1:0] rec_cause; // Only recorded in remote mode
  assign rec_cause = remote_active ? cause : '0;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else if (rd_status) begin
      status <= rec_cause;
    end else begin
      status <= status | rec_cause;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask <= MASK_RESET;
    end else if (wr_mask) begin
      mask <= reg_wdata[CAUSE_W-1:0];
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Read data in the cycle after the strobe, zero elsewhere
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFF_UPD_ADDR: next_rdata[BOOT_W-1:0] = upd_addr;
        OFF_UPD_WD: next_rdata[12:0] = upd_wd;
        OFF_CTL_ADDR: next_rdata[BOOT_W-1:0] = ctl_addr;
        OFF_CTL_WD: next_rdata[12:0] = ctl_wd;
        OFF_STATUS: next_rdata[CAUSE_W-1:0] = status;
        OFF_MASK: next_rdata[CAUSE_W-1:0] = mask;
        OFF_INFO: begin
          next_rdata[0] = factory_image;
          next_rdata[1] = user_mode;
          next_rdata[2] = remote_active;
          next_rdata[4:3] = scheme;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// file: design/upgrade_pkg.sv
package upgrade_pkg;

  // Bus and field widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int BOOT_W = 24;
  localparam int WD_W = 12;
  localparam int WD_CNT_W = 29;
  localparam int CAUSE_W = 4;
  localparam int SYNC_W = 12;

  // Register offsets, one word each
  localparam logic [3:0] OFF_UPD_ADDR = 4'h0;
  localparam logic [3:0] OFF_UPD_WD = 4'h1;
  localparam logic [3:0] OFF_CTL_ADDR = 4'h2;
  localparam logic [3:0] OFF_CTL_WD = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_MASK = 4'h5;
  localparam logic [3:0] OFF_COMMAND = 4'h6;
  localparam logic [3:0] OFF_INFO = 4'h7;

  // Watchdog word layout: timeout in [11:0], enable at bit 12
  localparam int WD_EN_BIT = 12;
  // Low 17 bits appended under the 12-bit timeout
  localparam logic [16:0] WD_LOW_BITS = 17'h0_0008;

  // Command word bits
  localparam int CMD_RECONFIG_BIT = 0;
  localparam int CMD_WD_RESTART_BIT = 1;

  // Cause bits, shared by status and mask
  localparam int CAUSE_STATUS_LINE = 0;
  localparam int CAUSE_CRC = 1;
  localparam int CAUSE_WDOG = 2;
  localparam int CAUSE_CFG_RESET = 3;

  // Factory boot addresses after power-up
  localparam logic [23:0] SERIAL_FACTORY_ADDR = 24'h00_0000;
  localparam logic [23:0] PARALLEL_FACTORY_ADDR = 24'h01_0000;

  // Reset values of software registers
  localparam logic [23:0] UPD_ADDR_RESET = 24'h00_0000;
  localparam logic [12:0] UPD_WD_RESET = 13'h0000;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Scheme select pin codes
  localparam logic [3:0] SCHEME_SERIAL_CODE = 4'h2;
  localparam logic [3:0] SCHEME_PARALLEL_CODE = 4'h6;

  // Bit positions in the synchronised pin bundle
  localparam int PIN_STATUS_N = 0;
  localparam int PIN_REQUEST_N = 1;
  localparam int PIN_CRC = 2;
  localparam int PIN_LOAD_DONE = 3;
  localparam int PIN_OVR_CMD = 4;
  localparam int PIN_REMOTE_EN = 5;
  localparam int PIN_CHAIN = 6;
  localparam int PIN_SECURE = 7;
  localparam int PIN_SCHEME_LSB = 8;
  // Pin levels held while in reset (active-low lines idle high)
  localparam logic [11:0] PIN_RESET = 12'h003;

  typedef enum logic [1:0] {
    SCHEME_NONE,
    SCHEME_SERIAL,
    SCHEME_PARALLEL
  } scheme_t;

  typedef enum {
    ST_START,
    ST_COPY,
    ST_LOAD,
    ST_USER
  } seq_state_t;

  // One decode for standard and remote update mode alike
  function automatic scheme_t decode_scheme(input logic [3:0] pins);
    scheme_t s;
    s = SCHEME_NONE;
    if (pins == SCHEME_SERIAL_CODE) begin
      s = SCHEME_SERIAL;
    end else if (pins == SCHEME_PARALLEL_CODE) begin
      s = SCHEME_PARALLEL;
    end
    return s;
  endfunction

endpackage

// file: design/pin_sync_if.sv
`timescale 1ns/100ps
// Raw pin bundle in, filtered bundle out
interface pin_sync_if #(parameter int W = 12);
  logic [W-1:0] raw; // Straight from the pins
  logic [W-1:0] clean; // After three flops and agreement
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// file: design/pin_filter.sv
`timescale 1ns/100ps
module pin_filter
  import upgrade_pkg::*;
#(
  parameter int W = 12,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Pin bundle
  pin_sync_if.filt pins
);

  logic [W-1:0] stage1; // Metastable catch, read only by stage2
  logic [W-1:0] stage2; // Second flop
  logic [W-1:0] stage3; // Third flop
  logic [W-1:0] held; // Accepted level

  // Three-flop chain
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once stage2 and stage3 agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          held[i] <= INIT[i];
        end else if (stage2[i] == stage3[i]) begin
          held[i] <= stage3[i];
        end
      end
    end
  endgenerate

  assign pins.clean = held;

endmodule

// file: bench/upgrade_chk.sv
`timescale 1ns/100ps
// Pin-level watcher for the sequencer
module upgrade_chk
  import upgrade_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Watched pins
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic remote_mode_enable,
  input wire logic chain_member,
  input wire logic factory_address_override_cmd,
  input wire logic image_crc_error,
  input wire logic load_request,
  input wire logic [BOOT_W-1:0] load_address,
  input wire logic load_word_units,
  input wire logic user_mode,
  input wire logic factory_image,
  input wire logic remote_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic prev_cmd; // Override pin one cycle back
  logic ovr_seen; // Default parallel address replaced
  // Once overridden, the default address check stands aside
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_cmd <= 1'b0;
      ovr_seen <= 1'b0;
    end else begin
      prev_cmd <= factory_address_override_cmd;
      ovr_seen <= ovr_seen | (factory_address_override_cmd & ~prev_cmd);
    end
  end
  // Factory fetch launches, per scheme
  sequence serial_fetch;
    $rose(load_request) && factory_image && !load_word_units;
  endsequence
  sequence parallel_fetch;
    $rose(load_request) && factory_image && load_word_units && !ovr_seen;
  endsequence
  // CRC fault on an application fetch, then factory reload
  sequence crc_in_app;
    $rose(image_crc_error) && load_request && !factory_image;
  endsequence
  sequence back_to_factory;
    ##[1:10] (factory_image && !user_mode);
  endsequence
  a_serial_factory_addr: assert property (
    serial_fetch |-> load_address == SERIAL_FACTORY_ADDR)
    else $error("serial factory fetch from wrong address");
  a_parallel_factory_addr: assert property (
    parallel_fetch |-> load_address == PARALLEL_FACTORY_ADDR)
    else $error("parallel factory fetch from wrong address");
  a_crc_falls_back: assert property (
    crc_in_app |-> back_to_factory)
    else $error("no factory fallback after crc fault");
  a_rdata_only_after: assert property (
    !$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_user_no_fetch: assert property (
    user_mode |-> !load_request)
    else $error("fetch requested while running");
  a_user_ends_fetch: assert property (
    $rose(user_mode) |-> $past(load_request) && !load_request)
    else $error("user mode without finished fetch");
  a_fetch_addr_steady: assert property (
    load_request && $past(load_request) |-> $stable(load_address))
    else $error("fetch address moved mid fetch");
  a_chain_blocks: assert property (
    chain_member [*6] |=> !remote_active)
    else $error("upgrade active in a chain");
  a_standard_off: assert property (
    !remote_mode_enable [*6] |=> !remote_active)
    else $error("upgrade active in standard mode");
endmodule

bind remote_image_upgrade_sequencer upgrade_chk chk_u (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .remote_mode_enable(remote_mode_enable),
  .chain_member(chain_member),
  .factory_address_override_cmd(factory_address_override_cmd),
  .image_crc_error(image_crc_error),
  .load_request(load_request),
  .load_address(load_address),
  .load_word_units(load_word_units),
  .user_mode(user_mode),
  .factory_image(factory_image),
  .remote_active(remote_active)
);

// file: bench/fetch_engine_model.sv
`timescale 1ns/100ps
// Flash fetch engine behind the load port
module fetch_engine_model (
  // Clock
  input wire logic clk_sys,
  // Request from the sequencer
  input wire logic load_request,
  input wire logic factory_image,
  // Bench controls: fetch time and fault injection
  input wire logic [7:0] fetch_delay,
  input wire logic crc_inject,
  // Results
  output logic image_crc_error,
  output logic image_load_done
);
  logic [7:0] elapsed; // Cycles into the current fetch
  // Restart timing on each new request; saturate to avoid wrap
  always_ff @(posedge clk_sys) begin
    if (!load_request) begin
      elapsed <= 8'h00;
    end else if (elapsed != 8'hff) begin
      elapsed <= elapsed + 8'h01;
    end
  end
  // Faults hit application images only, so the fallback stays clean
  assign image_crc_error = load_request && crc_inject && !factory_image;
  // Any start address loads alike
  assign image_load_done = load_request && !image_crc_error &&
    elapsed >= fetch_delay;
endmodule

// file: bench/remote_image_upgrade_sequencer_bench.sv
`timescale 1ns/100ps
module remote_image_upgrade_sequencer_bench
  import upgrade_pkg::*;
;
  typedef struct {logic wr; logic [3:0] addr; logic [31:0] data;} row_t;
  // Pins, all idle at time zero
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic status_n = 1'b1;
  logic request_n = 1'b1;
  logic [3:0] scheme = SCHEME_SERIAL_CODE;
  logic remote_en = 1'b1;
  logic chain = 1'b0;
  logic secure = 1'b0;
  logic ovr_cmd = 1'b0;
  logic [23:0] ovr_addr = 24'h00_0000;
  logic [7:0] fetch_delay = 8'h14; // Slow flash first
  logic crc_inject = 1'b0;
  logic [31:0] reg_rdata;
  logic crc_err, load_done, load_request, word_units;
  logic [23:0] load_address;
  logic user_mode, factory_image, remote_active, irq;
  int err_total = 0;
  int num_checks = 0;
  // Write/read rows: reset values, readback, read-only, unmapped
  row_t rows [0:9] = '{
    '{1'b0, OFF_UPD_WD, 32'h0000_0000}, '{1'b0, OFF_MASK, 32'h0000_0000},
    '{1'b1, OFF_UPD_ADDR, 32'h0012_3400},
    '{1'b0, OFF_UPD_ADDR, 32'h0012_3400},
    '{1'b1, OFF_MASK, 32'h0000_000f}, '{1'b0, OFF_MASK, 32'h0000_000f},
    '{1'b1, OFF_CTL_ADDR, 32'h0000_5500},
    '{1'b0, OFF_CTL_ADDR, 32'h0000_0000},
    '{1'b0, 4'h9, 32'h0000_0000}, '{1'b0, OFF_INFO, 32'h0000_000f}};

  remote_image_upgrade_sequencer dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .config_status_line_n(status_n),
    .config_request_n(request_n), .scheme_select_pins(scheme),
    .remote_mode_enable(remote_en), .chain_member(chain),
    .security_variant(secure), .factory_address_override_cmd(ovr_cmd),
    .override_address(ovr_addr), .image_crc_error(crc_err),
    .image_load_done(load_done), .load_request(load_request),
    .load_address(load_address), .load_word_units(word_units),
    .user_mode(user_mode), .factory_image(factory_image),
    .remote_active(remote_active), .irq(irq));

  fetch_engine_model model_u (
    .clk_sys(clk_sys), .load_request(load_request),
    .factory_image(factory_image), .fetch_delay(fetch_delay),
    .crc_inject(crc_inject), .image_crc_error(crc_err),
    .image_load_done(load_done));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // Wait for the old image to stop, then the expected one to run
  task automatic wait_user(input logic f, input logic [23:0] a,
      input logic u);
    int n;
    n = 0;
    while (user_mode !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    while (!(user_mode === 1'b1 && factory_image === f) && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    #1 check(32'(n < 400), 32'h0000_0001);
    check(32'(load_address), 32'(a));
    check(32'(word_units), 32'(u));
  endtask

  // Hold a pin request long enough to pass the filter
  task automatic pin_reset();
    request_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    request_n <= 1'b1;
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, well past the longest expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    wait_user(1'b1, 24'h00_0000, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].wr)
        reg_write(rows[i].addr, rows[i].data);
      else
        reg_read(rows[i].addr, rows[i].data);
    end
    fetch_delay <= 8'h02; // Prompt flash from here on
    reg_write(OFF_COMMAND, 32'h0000_0001);
    wait_user(1'b0, 24'h12_3400, 1'b0);
    reg_read(OFF_CTL_ADDR, 32'h0012_3400);
    reg_write(OFF_UPD_ADDR, 32'h00ab_cdef);
    reg_read(OFF_UPD_ADDR, 32'h0012_3400);
    reg_write(OFF_COMMAND, 32'h0000_0001);
    wait_user(1'b1, 24'h00_0000, 1'b0);
    check(32'(irq), 32'h0000_0001);
    reg_read(OFF_STATUS, 32'h0000_0008);
    @(posedge clk_sys);
    #1 check(32'(irq), 32'h0000_0000);
    // Watchdog armed with the shortest timeout, restarted, then left
    reg_write(OFF_UPD_WD, 32'h0000_1000);
    reg_write(OFF_COMMAND, 32'h0000_0001);
    wait_user(1'b0, 24'h12_3400, 1'b0);
    // Restarts every other cycle keep the application alive
    repeat (8) reg_write(OFF_COMMAND, 32'h0000_0002);
    #1 check(32'(user_mode && !factory_image), 32'h0000_0001);
    reg_read(OFF_CTL_WD, 32'h0000_1000);
    // Restarts stop here, so the timeout must fire
    wait_user(1'b1, 24'h00_0000, 1'b0);
    reg_read(OFF_STATUS, 32'h0000_0004);
    // CRC fault during the application fetch
    reg_write(OFF_UPD_WD, 32'h0000_0000);
    crc_inject <= 1'b1;
    reg_write(OFF_COMMAND, 32'h0000_0001);
    wait_user(1'b1, 24'h00_0000, 1'b0);
    crc_inject <= 1'b0;
    reg_read(OFF_STATUS, 32'h0000_0002);
    // Status line pulled low while its interrupt is masked
    reg_write(OFF_MASK, 32'h0000_000e);
    status_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    status_n <= 1'b1;
    wait_user(1'b1, 24'h00_0000, 1'b0);
    check(32'(irq), 32'h0000_0000);
    reg_write(OFF_MASK, 32'h0000_000f);
    @(posedge clk_sys);
    #1 check(32'(irq), 32'h0000_0001);
    reg_read(OFF_STATUS, 32'h0000_0001);
    // Parallel flash: default factory address, then the override
    @(posedge clk_sys);
    scheme <= SCHEME_PARALLEL_CODE;
    pin_reset();
    wait_user(1'b1, 24'h01_0000, 1'b1);
    reg_read(OFF_STATUS, 32'h0000_0008);
    @(posedge clk_sys);
    ovr_addr <= 24'h0a_bc00;
    repeat (2) @(posedge clk_sys);
    ovr_cmd <= 1'b1;
    repeat (8) @(posedge clk_sys);
    ovr_cmd <= 1'b0;
    pin_reset();
    wait_user(1'b1, 24'h0a_bc00, 1'b1);
    // Modes that must keep the upgrade logic off
    @(posedge clk_sys);
    secure <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check(32'(remote_active), 32'h0000_0000);
    @(posedge clk_sys);
    secure <= 1'b0;
    chain <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check(32'(remote_active), 32'h0000_0000);
    @(posedge clk_sys);
    chain <= 1'b0;
    remote_en <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 check(32'(remote_active), 32'h0000_0000);
    @(posedge clk_sys);
    remote_en <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check(32'(remote_active), 32'h0000_0001);
    close_out();
  end
endmodule
